// [hw/supervisor_pkg.sv]
package supervisor_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLOCK_MHZ = 100;
  localparam int HOLD_NORMAL_MS = 96;   // recovery select 0, halt 0
  localparam int HOLD_DEFAULT_MS = 40;  // recovery select 0, halt 1
  localparam int HOLD_SHORT_US = 50;    // recovery select 1
  localparam int CHECK_INTERVAL_H = 24; // battery re-check period
  localparam int HOLD_NORMAL_CYC = HOLD_NORMAL_MS * 1000 * CLOCK_MHZ;
  localparam int HOLD_DEFAULT_CYC = HOLD_DEFAULT_MS * 1000 * CLOCK_MHZ;
  localparam int HOLD_SHORT_CYC = HOLD_SHORT_US * CLOCK_MHZ;
  localparam longint CHECK_INTERVAL_CYC = longint'(CHECK_INTERVAL_H) * 3600 * 1000000 *
    longint'(CLOCK_MHZ);
  localparam int HOLD_CNT_W = 24;
  localparam int CHECK_CNT_W = 48;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CENTURY = 8'h03;
  localparam logic [7:0] IDX_DESELECT_HOLD_TIME = 8'h04;
  localparam logic [7:0] IDX_CONTROL = 8'h08;
  localparam logic [7:0] IDX_WATCHDOG = 8'h09;
  localparam logic [7:0] IDX_ENABLES = 8'h0a;
  localparam logic [7:0] IDX_FLAGS = 8'h0f;
  localparam logic [7:0] IDX_STATUS = 8'h10;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_CENTURY_EN = 7;
  localparam int BIT_CENTURY_TOG = 6;
  localparam int BIT_REC_SHORT = 7;
  localparam int BIT_PIN_LEVEL = 7;
  localparam int BIT_FREQ_TEST = 6;
  localparam int BIT_ALARM_PIN = 7;
  localparam int BIT_SQUARE = 6;
  localparam int BIT_ALARM_BKP = 5;
  localparam int BIT_BATT_LOW = 4;
  localparam int BIT_OSC_HALT = 7;
  localparam int BIT_HALT_UPD = 6;
  localparam int BIT_WD_STEER = 7;

  // ---------------------------------------------------------------
  // values after first power application
  // ---------------------------------------------------------------
  localparam logic [7:0] WATCHDOG_RESET = 8'h00;
  localparam logic RESET_OSC_HALT = 1'b1;
  localparam logic RESET_PIN_LEVEL = 1'b1;
  localparam logic RESET_HALT_UPD = 1'b1;
  localparam logic RESET_REC_SHORT = 1'b0;

  // hold length selector
  typedef enum logic [1:0] {
    HOLD_NORMAL = 2'b00,
    HOLD_DEFAULT = 2'b01,
    HOLD_SHORT = 2'b10
  } hold_sel_type;

  // supply state
  typedef enum logic [1:0] {
    PWR_BACKUP = 2'b00,
    PWR_RECOVER = 2'b01,
    PWR_RUN = 2'b10
  } power_state_type;

endpackage

// [hw/supervisor_if.sv]
`timescale 1ns/1ps
interface supervisor_if;
  import supervisor_pkg::*;
  logic hold_start;
  hold_sel_type hold_sel;
  logic hold_busy;
  logic power_good;
  logic check_now;
  modport ctrl(output hold_start, output hold_sel, output power_good,
    input hold_busy, input check_now);
  modport timer(input hold_start, input hold_sel, output hold_busy);
  modport sched(input power_good, output check_now);
endinterface // supervisor_if

// [hw/recovery_timer.sv]
`timescale 1ns/1ps
module recovery_timer
  import supervisor_pkg::*;
#(
  parameter int NORMAL_CYCLES = HOLD_NORMAL_CYC,
  parameter int DEFAULT_CYCLES = HOLD_DEFAULT_CYC,
  parameter int SHORT_CYCLES = HOLD_SHORT_CYC
) (
  input wire logic clock_in,
  input wire logic rst_n,
  supervisor_if.timer bus
);
  logic [HOLD_CNT_W-1:0] remain;

  // counts down the selected hold length after each start
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      remain <= '0;
    end else if (bus.hold_start) begin
      case (bus.hold_sel)
        HOLD_NORMAL: remain <= HOLD_CNT_W'(NORMAL_CYCLES);
        HOLD_DEFAULT: remain <= HOLD_CNT_W'(DEFAULT_CYCLES);
        HOLD_SHORT: remain <= HOLD_CNT_W'(SHORT_CYCLES);
        default: remain <= HOLD_CNT_W'(NORMAL_CYCLES);
      endcase
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  assign bus.hold_busy = (remain != '0);
endmodule // recovery_timer

// [hw/battery_check_scheduler.sv]
`timescale 1ns/1ps
module battery_check_scheduler
  import supervisor_pkg::*;
#(
  parameter longint INTERVAL_CYCLES = CHECK_INTERVAL_CYC
) (
  input wire logic clock_in,
  input wire logic rst_n,
  supervisor_if.sched bus
);
  logic [CHECK_CNT_W-1:0] elapsed;
  logic good_seen;

  // one check at each power-up, then one per interval while powered
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      elapsed <= '0;
      good_seen <= 1'b0;
      bus.check_now <= 1'b0;
    end else begin
      good_seen <= bus.power_good;
      bus.check_now <= 1'b0;
      if (!bus.power_good) begin
        elapsed <= '0;
      end else if (!good_seen) begin
        bus.check_now <= 1'b1;
        elapsed <= '0;
      end else if (elapsed == CHECK_CNT_W'(INTERVAL_CYCLES - 1)) begin
        bus.check_now <= 1'b1;
        elapsed <= '0;
      end else begin
        elapsed <= elapsed + 1'b1;
      end
    end
  end
endmodule // battery_check_scheduler

// [hw/supply_supervisor.sv]
`timescale 1ns/1ps
module supply_supervisor
  import supervisor_pkg::*;
#(
  parameter int NORMAL_CYCLES = HOLD_NORMAL_CYC,
  parameter int DEFAULT_CYCLES = HOLD_DEFAULT_CYC,
  parameter int SHORT_CYCLES = HOLD_SHORT_CYC,
  parameter longint INTERVAL_CYCLES = CHECK_INTERVAL_CYC
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // analogue and timebase events
  input wire logic supply_good_in,
  input wire logic sense_below_in,
  input wire logic battery_below_in,
  input wire logic century_rollover_in,
  // pins
  output logic supply_fail_signal_out,
  output logic reset_pin_b_out,
  output logic reset_pin_oe_out,
  output logic shared_interrupt_pin_out,
  output logic shared_interrupt_pin_oe_out,
  output logic deselect_out
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (NORMAL_CYCLES < 1 || DEFAULT_CYCLES < 1 || SHORT_CYCLES < 1 ||
      longint'(NORMAL_CYCLES) >= (64'h1 << HOLD_CNT_W) ||
      longint'(DEFAULT_CYCLES) >= (64'h1 << HOLD_CNT_W) ||
      longint'(SHORT_CYCLES) >= (64'h1 << HOLD_CNT_W)) begin : g_bad_hold
    $error("hold cycle counts out of range");
  end
  if (INTERVAL_CYCLES < 2 || INTERVAL_CYCLES >= (64'h1 << CHECK_CNT_W)) begin : g_bad_check
    $error("check interval out of range");
  end

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // two flip-flops release the asynchronous reset
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  supervisor_if sup ();
  power_state_type pstate;
  logic osc_halt;
  logic rec_short;

  recovery_timer #(
    .NORMAL_CYCLES(NORMAL_CYCLES),
    .DEFAULT_CYCLES(DEFAULT_CYCLES),
    .SHORT_CYCLES(SHORT_CYCLES)
  ) u_timer (
    .clock_in(clock_in),
    .rst_n(rst_n),
    .bus(sup.timer)
  );

  battery_check_scheduler #(
    .INTERVAL_CYCLES(INTERVAL_CYCLES)
  ) u_sched (
    .clock_in(clock_in),
    .rst_n(rst_n),
    .bus(sup.sched)
  );

  // hold length from the short select and the halt bit
  always_comb begin
    sup.hold_start = (pstate == PWR_BACKUP) && supply_good_in;
    if (rec_short) begin
      sup.hold_sel = HOLD_SHORT;
    end else if (osc_halt) begin
      sup.hold_sel = HOLD_DEFAULT;
    end else begin
      sup.hold_sel = HOLD_NORMAL;
    end
  end

  assign sup.power_good = (pstate == PWR_RUN) && supply_good_in;

  // ---------------------------------------------------------------
  // supply state machine
  // ---------------------------------------------------------------
  power_state_type next_pstate;

  always_comb begin
    next_pstate = pstate;
    case (pstate)
      PWR_BACKUP: begin
        if (supply_good_in) begin
          next_pstate = PWR_RECOVER;
        end
      end
      PWR_RECOVER: begin
        if (!supply_good_in) begin
          next_pstate = PWR_BACKUP;
        end else if (!sup.hold_busy) begin
          next_pstate = PWR_RUN;
        end
      end
      PWR_RUN: begin
        if (!supply_good_in) begin
          next_pstate = PWR_BACKUP;
        end
      end
      default: next_pstate = PWR_BACKUP;
    endcase
  end

  // state register
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pstate <= PWR_BACKUP;
    end else begin
      pstate <= next_pstate;
    end
  end

  logic power_up;
  assign power_up = (pstate == PWR_BACKUP) && supply_good_in;

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  logic [7:0] index;
  logic mapped;
  logic commit;
  logic access_ok;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  assign index = paddr_in[9:2];
  assign wbyte = pwdata_in[7:0];
  assign mapped = (paddr_in[1:0] == 2'b00) && (paddr_in[11:10] == 2'b00) &&
    (index == IDX_CENTURY || index == IDX_DESELECT_HOLD_TIME || index == IDX_CONTROL ||
     index == IDX_WATCHDOG || index == IDX_ENABLES || index == IDX_FLAGS ||
     index == IDX_STATUS);
  // write lands at the edge where the master samples pready
  assign commit = psel_in && penable_in && pready_out && pwrite_in && access_ok;

  // one wait state, then answer with data and error
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= '0;
      access_ok <= 1'b0;
    end else begin
      pready_out <= psel_in && penable_in && !pready_out;
      if (psel_in && penable_in && !pready_out) begin
        access_ok <= mapped && !(pwrite_in && pstate != PWR_RUN);
        pslverr_out <= !mapped || (pwrite_in && pstate != PWR_RUN);
        prdata_out <= {24'h000000, (pwrite_in || !mapped) ? 8'h00 : rbyte}; // refused reads give 0
      end else begin
        access_ok <= 1'b0;
        pslverr_out <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // control bits
  // ---------------------------------------------------------------
  logic century_en;
  logic century_tog;
  logic pin_level;
  logic freq_test;
  logic alarm_pin;
  logic alarm_bkp;
  logic square_en;
  logic halt_upd;
  logic batt_low;
  logic [7:0] watchdog;

  // century bits; a rollover toggles even a value written that cycle
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      century_en <= 1'b0;
      century_tog <= 1'b0;
    end else begin
      if (commit && index == IDX_CENTURY) begin
        century_en <= wbyte[BIT_CENTURY_EN];
        century_tog <= wbyte[BIT_CENTURY_TOG] ^
          (century_rollover_in & wbyte[BIT_CENTURY_EN]);
      end else if (century_rollover_in && century_en) begin
        century_tog <= !century_tog;
      end
    end
  end

  // bits kept across back-up; reset gives first power-up values
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      rec_short <= RESET_REC_SHORT;
      osc_halt <= RESET_OSC_HALT;
      pin_level <= RESET_PIN_LEVEL;
    end else if (commit) begin
      if (index == IDX_DESELECT_HOLD_TIME) begin
        rec_short <= wbyte[BIT_REC_SHORT];
      end
      if (index == IDX_STATUS) begin
        osc_halt <= wbyte[BIT_OSC_HALT];
      end
      if (index == IDX_CONTROL) begin
        pin_level <= wbyte[BIT_PIN_LEVEL];
      end
    end
  end

  // bits reset at every power-up: halt_upd set, the rest cleared
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      freq_test <= 1'b0;
      alarm_pin <= 1'b0;
      alarm_bkp <= 1'b0;
      square_en <= 1'b0;
      watchdog <= WATCHDOG_RESET;
      halt_upd <= RESET_HALT_UPD;
    end else if (power_up) begin
      freq_test <= 1'b0;
      alarm_pin <= 1'b0;
      alarm_bkp <= 1'b0;
      square_en <= 1'b0;
      watchdog <= WATCHDOG_RESET;
      halt_upd <= 1'b1;
    end else if (commit) begin
      if (index == IDX_CONTROL) begin
        freq_test <= wbyte[BIT_FREQ_TEST];
      end
      if (index == IDX_WATCHDOG) begin
        watchdog <= wbyte;
      end
      if (index == IDX_ENABLES) begin
        alarm_pin <= wbyte[BIT_ALARM_PIN];
        alarm_bkp <= wbyte[BIT_ALARM_BKP];
        square_en <= wbyte[BIT_SQUARE];
      end
      if (index == IDX_STATUS) begin
        halt_upd <= wbyte[BIT_HALT_UPD];
      end
    end
  end

  // battery low flag follows each check result
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      batt_low <= 1'b0;
    end else if (sup.check_now) begin
      batt_low <= battery_below_in;
    end
  end

  // read mux
  always_comb begin
    rbyte = 8'h00;
    case (index)
      IDX_CENTURY: begin
        rbyte[BIT_CENTURY_EN] = century_en;
        rbyte[BIT_CENTURY_TOG] = century_tog;
      end
      IDX_DESELECT_HOLD_TIME: rbyte[BIT_REC_SHORT] = rec_short;
      IDX_CONTROL: begin
        rbyte[BIT_PIN_LEVEL] = pin_level;
        rbyte[BIT_FREQ_TEST] = freq_test;
      end
      IDX_WATCHDOG: rbyte = watchdog;
      IDX_ENABLES: begin
        rbyte[BIT_ALARM_PIN] = alarm_pin;
        rbyte[BIT_ALARM_BKP] = alarm_bkp;
        rbyte[BIT_SQUARE] = square_en;
      end
      IDX_FLAGS: rbyte[BIT_BATT_LOW] = batt_low;
      IDX_STATUS: begin
        rbyte[BIT_OSC_HALT] = osc_halt;
        rbyte[BIT_HALT_UPD] = halt_upd;
      end
      default: rbyte = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  logic driver_mode;
  assign driver_mode = !freq_test && !alarm_pin && (watchdog == 8'h00);

  // all pin outputs registered
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      supply_fail_signal_out <= 1'b0;
      reset_pin_b_out <= 1'b0;
      reset_pin_oe_out <= 1'b1;
      shared_interrupt_pin_out <= 1'b0;
      shared_interrupt_pin_oe_out <= 1'b0;
      deselect_out <= 1'b1;
    end else begin
      case (next_pstate)
        PWR_RUN: supply_fail_signal_out <= !sense_below_in;
        PWR_RECOVER: supply_fail_signal_out <= 1'b1;
        default: supply_fail_signal_out <= 1'b0;
      endcase
      reset_pin_b_out <= 1'b0;
      reset_pin_oe_out <= (next_pstate != PWR_RUN);
      deselect_out <= (next_pstate != PWR_RUN);
      shared_interrupt_pin_out <= 1'b0;
      shared_interrupt_pin_oe_out <= driver_mode && !pin_level;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n);

  a_fail_in_backup: assert property ((pstate == PWR_BACKUP && !supply_good_in) |=>
    !supply_fail_signal_out) else $error("fail output not low in back-up");
  a_fail_forced_high: assert property ((pstate == PWR_RECOVER && supply_good_in &&
    sup.hold_busy) |=> supply_fail_signal_out) else $error("fail output not forced high");
  a_fail_follows: assert property ((pstate == PWR_RUN && supply_good_in) |=>
    supply_fail_signal_out == !$past(sense_below_in)) else $error("fail output not following");
  a_century_toggle: assert property ((century_rollover_in && century_en && !commit) |=>
    century_tog != $past(century_tog)) else $error("century flag not toggled");
  a_century_hold: assert property ((century_rollover_in && !century_en && !commit) |=>
    $stable(century_tog)) else $error("century flag changed while disabled");
  a_pin_low: assert property ((driver_mode && !pin_level) |=> shared_interrupt_pin_oe_out)
    else $error("shared pin not pulled low");
  a_pin_never_high: assert property (!shared_interrupt_pin_out && !reset_pin_b_out)
    else $error("open drain pin driven high");
  a_pin_wd_release: assert property ((watchdog != 8'h00) |=> !shared_interrupt_pin_oe_out)
    else $error("shared pin driven with watchdog set");
  a_batt_check: assert property (sup.check_now |=> batt_low == $past(battery_below_in))
    else $error("battery flag not updated");
  a_no_check_backup: assert property ((pstate != PWR_RUN) |=> !sup.check_now)
    else $error("battery check outside main supply");
  a_write_reject: assert property ((psel_in && penable_in && !pready_out && pwrite_in &&
    pstate != PWR_RUN) |=> pslverr_out) else $error("write not rejected in deselect");
  a_powerup_clear: assert property (power_up |=> (watchdog == 8'h00 && !freq_test &&
    !alarm_pin && halt_upd)) else $error("power-up defaults not applied");
  a_reset_held: assert property ((next_pstate != PWR_RUN) |=> reset_pin_oe_out)
    else $error("reset pin released early");

endmodule // supply_supervisor

// [bench/apb_host.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// host processor on the register bus
// ---------------------------------------------------------------
module apb_host (
  // clock
  input wire logic clock_in,
  // request
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out,
  // answer
  input wire logic pready_in
);
  // idle bus at time zero
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0;
  end

  // one transfer: setup, then access held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] data);
    @(posedge clock_in);
    psel_out <= 1'b1;
    pwrite_out <= wr;
    paddr_out <= {2'b00, idx, 2'b00};
    pwdata_out <= {24'h0, data};
    @(posedge clock_in);
    penable_out <= 1'b1;
    do begin
      @(posedge clock_in);
    end while (pready_in !== 1'b1); // only the bench timeout ends a wait
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~paddr_out; // released lines do not keep old values
    pwdata_out <= ~pwdata_out;
  endtask
endmodule // apb_host

// [bench/supply_supervisor_tb.sv]
`timescale 1ns/1ps
module supply_supervisor_tb
  import supervisor_pkg::*;
();
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic clock_in, rst_b_in, psel, penable, pwrite, supply_good, sense_below, batt_below, roll;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_out;
  logic pready_out, pslverr_out, fail_out, rst_pin_out, rst_oe, pin_out, pin_oe, deselect;
  logic [9:0] exp_q[$];
  logic [9:0] e;
  logic [7:0] wd;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [7:0] ridx [5] = '{IDX_DESELECT_HOLD_TIME, IDX_CONTROL, IDX_WATCHDOG, IDX_ENABLES, IDX_STATUS};
  logic [7:0] rexp [2][5] = '{'{8'h00, 8'h80, 8'h00, 8'h00, 8'hc0},
    '{8'h80, 8'h00, 8'h00, 8'h00, 8'hc0}};

  supply_supervisor #(.NORMAL_CYCLES(40), .DEFAULT_CYCLES(30), .SHORT_CYCLES(10),
    .INTERVAL_CYCLES(200)) dut_u (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .supply_good_in(supply_good), .sense_below_in(sense_below),
    .battery_below_in(batt_below), .century_rollover_in(roll),
    .supply_fail_signal_out(fail_out), .reset_pin_b_out(rst_pin_out),
    .reset_pin_oe_out(rst_oe), .shared_interrupt_pin_out(pin_out),
    .shared_interrupt_pin_oe_out(pin_oe), .deselect_out(deselect));
  apb_host host_u (.clock_in(clock_in), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .pready_in(pready_out));

  // 100 mhz clock
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t output %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic err);
    exp_q.push_back({1'b0, err, 8'h00});
    host_u.xfer(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic err);
    exp_q.push_back({1'b1, err, d});
    host_u.xfer(1'b0, idx, d);
  endtask
  task automatic pulse();
    @(posedge clock_in);
    roll <= 1'b1;
    @(posedge clock_in);
    roll <= 1'b0;
  endtask
  // supply returns with the sense input high; fail output high only while recovering
  task automatic power_up(input int hold);
    @(posedge clock_in);
    supply_good <= 1'b1;
    cyc(hold - 5);
    @(negedge clock_in);
    chk(fail_out, 1'b1);
    chk(rst_oe, 1'b1);
    cyc(15);
    @(negedge clock_in);
    chk(fail_out, 1'b0);
    chk(deselect, 1'b0);
    chk(rst_oe, 1'b0);
  endtask
  task automatic reg_table(input int k);
    for (int i = 0; i < 5; i++) rd(ridx[i], rexp[k][i], 1'b0);
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // answer monitor: every pready takes the oldest note
  always @(posedge clock_in) begin
    if (pready_out === 1'b1 && exp_q.size() == 0) begin
      error_cnt++;
      $display("FAIL t=%0t bus answer with no request noted", $time);
    end else if (pready_out === 1'b1) begin
      e = exp_q.pop_front();
      samples_checked++;
      if (pslverr_out !== e[8] || (e[9] && prdata_out !== {24'h0, e[7:0]})) begin
        error_cnt++;
        $display("FAIL t=%0t bus answer %h err %b", $time, prdata_out, pslverr_out);
      end
    end
  end

  // hang guard
  initial begin
    #200000;
    error_cnt++;
    $display("FAIL t=%0t timeout", $time);
    end_of_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] mctl [6];
    logic [7:0] mwd [6];
    logic [7:0] men [6];
    logic mexp [6];
    void'($urandom(32'h47245ed0));
    wd = 8'($urandom) | 8'h01;
    mctl = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
    mwd = '{8'h00, 8'h00, wd, 8'h00, 8'h00, 8'h00};
    men = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
    mexp = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    rst_b_in = 1'b0;
    supply_good = 1'b0;
    sense_below = 1'b1;
    batt_below = 1'b1;
    roll = 1'b0;
    cyc(8);
    rst_b_in <= 1'b1;
    cyc(4);
    @(negedge clock_in);
    chk(fail_out, 1'b0);
    chk(deselect, 1'b1);
    chk(rst_oe, 1'b1);
    wr(IDX_CENTURY, 8'h80, 1'b1);
    cyc(250);
    rd(IDX_FLAGS, 8'h00, 1'b0);
    power_up(30);
    rd(IDX_FLAGS, 8'h10, 1'b0);
    batt_below <= 1'b0;
    rd(IDX_FLAGS, 8'h10, 1'b0);
    cyc(200);
    rd(IDX_FLAGS, 8'h00, 1'b0);
    sense_below <= 1'b0;
    cyc(3);
    chk(fail_out, 1'b1);
    sense_below <= 1'b1;
    cyc(3);
    chk(fail_out, 1'b0);
    reg_table(0);
    rd(8'h05, 8'h00, 1'b1);
    for (int i = 0; i < 6; i++) begin
      wr(IDX_CONTROL, mctl[i], 1'b0);
      wr(IDX_WATCHDOG, mwd[i], 1'b0);
      wr(IDX_ENABLES, men[i], 1'b0);
      cyc(3);
      @(negedge clock_in);
      chk(pin_oe, mexp[i]);
      chk(pin_out, 1'b0);
      chk(rst_pin_out, 1'b0);
    end
    wr(IDX_CENTURY, 8'h80, 1'b0);
    pulse();
    rd(IDX_CENTURY, 8'hc0, 1'b0);
    pulse();
    rd(IDX_CENTURY, 8'h80, 1'b0);
    wr(IDX_CENTURY, 8'h40, 1'b0);
    pulse();
    rd(IDX_CENTURY, 8'h40, 1'b0);
    wr(IDX_DESELECT_HOLD_TIME, 8'h80, 1'b0);
    rd(IDX_DESELECT_HOLD_TIME, 8'h80, 1'b0);
    wr(IDX_CONTROL, 8'h40, 1'b0);
    wr(IDX_WATCHDOG, wd, 1'b0);
    rd(IDX_WATCHDOG, wd, 1'b0);
    wr(IDX_ENABLES, 8'he0, 1'b0);
    @(posedge clock_in);
    supply_good <= 1'b0;
    cyc(3);
    @(negedge clock_in);
    chk(fail_out, 1'b0);
    chk(rst_oe, 1'b1);
    wr(IDX_DESELECT_HOLD_TIME, 8'h00, 1'b1);
    power_up(10);
    reg_table(1);
    cyc(5);
    // every noted request must have had its answer
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("FAIL t=%0t %0d bus answers missing", $time, exp_q.size());
    end
    end_of_test();
  end
endmodule // supply_supervisor_tb
